// ==== bmc_pkg.sv ====
// Shared constants, encodings and carriers of the barometer control block
`default_nettype none
package bmc_pkg;
  localparam logic [6:0]  I2C_ADDR       = 7'h77;
  localparam logic [7:0]  REG_PRS_B2     = 8'h00;
  localparam logic [7:0]  REG_PRS_B1     = 8'h01;
  localparam logic [7:0]  REG_PRS_B0     = 8'h02;
  localparam logic [7:0]  REG_TMP_B2     = 8'h03;
  localparam logic [7:0]  REG_TMP_B1     = 8'h04;
  localparam logic [7:0]  REG_TMP_B0     = 8'h05;
  localparam logic [7:0]  REG_PRESS_CFG  = 8'h06;
  localparam logic [7:0]  REG_TEMP_CFG   = 8'h07;
  localparam logic [7:0]  REG_MEAS_CFG   = 8'h08;
  localparam logic [7:0]  REG_CFG        = 8'h09;
  localparam logic [7:0]  REG_FIFO_STS   = 8'h0B;
  localparam logic [7:0]  REG_RESET      = 8'h0C;
  localparam logic [7:0]  REG_PROD_ID    = 8'h0D;
  localparam logic [7:0]  REG_COEF_LO    = 8'h10;
  localparam logic [7:0]  REG_COEF_HI    = 8'h21;
  localparam int          COEF_BYTES     = 18;
  localparam logic [7:0]  PRESS_CFG_MASK = 8'h7F;
  localparam logic [7:0]  CFG_MASK       = 8'h0E;
  localparam logic [7:0]  CFG_RESET_VAL  = 8'h00;
  localparam int          RATE_LSB       = 4;
  localparam int          PRC_LSB        = 0;
  localparam int          COEF_RDY_BIT   = 7;
  localparam int          SENSOR_RDY_BIT = 6;
  localparam int          TMP_RDY_BIT    = 5;
  localparam int          PRS_RDY_BIT    = 4;
  localparam int          FIFO_EN_BIT    = 1;
  localparam int          FLUSH_BIT      = 7;
  localparam logic [3:0]  SOFT_RST_CODE  = 4'h9;
  localparam logic [2:0]  PRC_MAX        = 3'h7;
  // Measurement control encodings
  localparam logic [2:0]  MODE_IDLE      = 3'h0;
  localparam logic [2:0]  MODE_CMD_PRS   = 3'h1;
  localparam logic [2:0]  MODE_CMD_TMP   = 3'h2;
  localparam logic [2:0]  MODE_BG_PRS    = 3'h5;
  localparam logic [2:0]  MODE_BG_TMP    = 3'h6;
  localparam logic [2:0]  MODE_BG_ALL    = 3'h7;
  // Timing
  localparam int          CLK_HZ         = 50_000_000;
  localparam int          MS_PER_S       = 1000;
  localparam int          MS_CYCLES      = CLK_HZ / MS_PER_S;
  localparam int          SENSOR_RDY_MS  = 12;
  localparam int          COEF_RDY_MS    = 40;
  localparam int          RESULT_DEPTH   = 32;

  typedef struct packed {
    logic        is_temp;
    logic [2:0]  prc;
  } bmc_req_t;

  typedef struct packed {
    logic        is_temp;
    logic [23:0] value;
  } bmc_result_t;

  typedef enum logic [8:0] {
    I_IDLE = 9'h001,
    I_ADDR = 9'h002,
    I_AACK = 9'h004,
    I_REG  = 9'h008,
    I_RACK = 9'h010,
    I_WR   = 9'h020,
    I_WACK = 9'h040,
    I_RD   = 9'h080,
    I_MACK = 9'h100
  } bmc_i2c_t;

  typedef enum logic [2:0] {
    SQ_IDLE  = 3'h1,
    SQ_CONV  = 3'h2,
    SQ_STORE = 3'h4
  } bmc_seq_t;
endpackage
`default_nettype wire

// ==== bmc_top.sv ====
// Barometer measurement control with I2C target and result buffer
//
// How it works
// - Three modes: standby, one-shot command, continuous background.
// - Reset enters standby; nothing is measured until a mode is chosen.
// - Standby leaves every register and coefficient reachable.
// - Command mode runs one conversion of either kind at set precision.
// - Finished command conversion stores result and drops back to standby.
// - Background mode repeats enabled conversions at set precision, rate.
// - With both enabled, a due temperature follows straight after pressure.
// - Background results can queue in a 32-entry buffer.
// - Higher precision averages several sensor samples, taking longer.
// - Pressure and temperature rates are set independently.
// - Target answers at 7-bit address 0x77.
// - Target port serves standard, fast and high-speed bus modes.
// - Register pointer advances after each byte within one transfer.
// - Every result is delivered as 24 bit two's complement.
// - Sensor ready within 12 ms, coefficients ready within 40 ms.
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module bmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys_i,   // System clock
  input  wire logic             srst_i,      // Sync reset
  input  wire logic             flush_i,     // Drop all entries
  input  wire logic             in_valid_i,  // Write request
  output logic                  in_ready_o,  // Room available
  input  wire logic [WIDTH-1:0] in_data_i,   // Write data
  output logic                  out_valid_o, // Entry available
  input  wire logic             out_ready_i, // Read accept
  output logic      [WIDTH-1:0] out_data_o,  // Head entry
  output logic                  full_o,      // Buffer full
  output logic                  empty_o      // Buffer empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign full_o      = (count == (AW+1)'(DEPTH));
  assign empty_o     = (count == '0);
  assign in_ready_o  = !full_o;
  assign out_valid_o = !empty_o;
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module bmc_top
  import bmc_pkg::*;
#(
  parameter int         MS_CYC  = MS_CYCLES, // Cycles per millisecond
  parameter logic [7:0] PROD_ID = 8'h5A      // Arbitrary identity value
) (
  input  wire logic                  clk_sys_i,      // 50 MHz clock
  input  wire logic                  srst_i,         // Sync reset, high
  input  wire logic                  scl_i,          // Bus clock pin
  input  wire logic                  sda_i,          // Bus data pin in
  output logic                       sda_o,          // Bus data out
  output logic                       sda_oe_o,       // Pull data low
  output logic                       conv_start_o,   // Take one sample
  output bmc_req_t                   conv_req_o,     // Sample kind
  input  wire logic                  sample_valid_i, // Sample done
  input  wire logic [23:0]           sample_i,       // Raw sample
  input  wire logic [8*COEF_BYTES-1:0] coef_i        // Stored coefficients
);
  // Reset and timers
  logic        soft_rst;
  logic        rst;
  logic [15:0] div_cnt;
  logic        ms_tick;
  logic [5:0]  up_ms;
  logic        sensor_rdy;
  logic        coef_rdy;
  // Pins
  logic [2:0]  scl_s;
  logic [2:0]  sda_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  // Target port
  bmc_i2c_t    i2c_st;
  logic [7:0]  shreg;
  logic [7:0]  tx;
  logic [3:0]  bitcnt;
  logic        rw;
  logic        nack;
  logic [7:0]  ptr;
  logic        wr_fire;
  logic        rd_load;
  logic [7:0]  rd_data;
  // Registers
  logic [7:0]  press_cfg;
  logic [7:0]  temp_cfg;
  logic [7:0]  cfg_reg;
  logic [2:0]  meas_mode;
  logic        mode_wr_pend;
  logic        prs_rdy;
  logic        tmp_rdy;
  logic [23:0] prs_res;
  logic [23:0] tmp_res;
  logic        fifo_en;
  // Sequencer
  bmc_seq_t    seq_st;
  bmc_req_t    next_req;
  logic [31:0] acc;
  logic [7:0]  nsamp;
  logic        last_samp;
  logic        run_cmd;
  logic        cmd_mode;
  logic [1:0]  bg_en;
  logic [1:0]  due;
  logic [9:0]  per_cnt [2];
  logic        start_go;
  bmc_result_t result;
  logic        store_fire;
  // Buffer
  logic        fifo_push;
  logic        fifo_rdy;
  logic        fifo_pop;
  logic        fifo_full;
  logic        fifo_empty;
  logic        fifo_flush;
  bmc_result_t fifo_head;

  function automatic logic [2:0] prc_of(input logic [7:0] cfg);
    prc_of = (cfg[PRC_LSB+3]) ? PRC_MAX : cfg[PRC_LSB +: 3];
  endfunction

  function automatic logic [9:0] period_ms(input logic [7:0] cfg);
    period_ms = 10'(MS_PER_S >> cfg[RATE_LSB +: 3]);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset, millisecond divider, start-up readiness
  assign rst        = srst_i || soft_rst;
  assign ms_tick    = (div_cnt == 16'(MS_CYC - 1));
  assign sensor_rdy = (up_ms >= 6'(SENSOR_RDY_MS));
  assign coef_rdy   = (up_ms >= 6'(COEF_RDY_MS));

  always_ff @(posedge clk_sys_i) begin
    soft_rst <= !srst_i && wr_fire && ptr == REG_RESET
                && shreg[3:0] == SOFT_RST_CODE;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      div_cnt <= '0;
      up_ms   <= '0;
    end else begin
      div_cnt <= ms_tick ? '0 : div_cnt + 1'b1;
      if (ms_tick && !coef_rdy) begin
        up_ms <= up_ms + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus conditions
  assign scl_rise  = scl_s[1] && !scl_s[2];
  assign scl_fall  = !scl_s[1] && scl_s[2];
  assign bus_start = scl_s[1] && scl_s[2] && sda_s[2] && !sda_s[1];
  assign bus_stop  = scl_s[1] && scl_s[2] && !sda_s[2] && sda_s[1];

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // I2C target: address match, pointer, auto-increment
  assign wr_fire  = scl_fall && i2c_st == I_WR && bitcnt == 4'h8;
  assign rd_load  = scl_fall && ((i2c_st == I_AACK && rw)
                    || (i2c_st == I_MACK && !nack));
  assign sda_o    = 1'b0;
  assign sda_oe_o = (i2c_st == I_AACK) || (i2c_st == I_RACK)
                    || (i2c_st == I_WACK) || (i2c_st == I_RD && !tx[7]);

  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      i2c_st <= I_IDLE;
      shreg  <= '0;
      tx     <= 8'hFF;
      bitcnt <= '0;
      rw     <= 1'b0;
      nack   <= 1'b0;
      ptr    <= '0;
    end else if (bus_start) begin
      i2c_st <= I_ADDR;
      bitcnt <= '0;
      tx     <= 8'hFF;
    end else if (bus_stop) begin
      i2c_st <= I_IDLE;
      tx     <= 8'hFF;
    end else if (scl_rise) begin
      if (i2c_st == I_MACK) begin
        nack <= sda_s[1];
      end else if (i2c_st inside {I_ADDR, I_REG, I_WR, I_RD}) begin
        shreg  <= {shreg[6:0], sda_s[1]};
        bitcnt <= bitcnt + 1'b1;
      end
    end else if (scl_fall) begin
      unique case (i2c_st)
        I_IDLE: i2c_st <= I_IDLE;
        I_ADDR: begin
          if (bitcnt == 4'h8) begin
            i2c_st <= (shreg[7:1] == I2C_ADDR) ? I_AACK : I_IDLE;
            rw     <= shreg[0];
          end
        end
        I_AACK, I_MACK: begin
          bitcnt <= '0;
          if (rw && !(i2c_st == I_MACK && nack)) begin
            i2c_st <= I_RD;
            tx     <= rd_data;
            ptr    <= ptr + 1'b1;
          end else begin
            i2c_st <= rw ? I_IDLE : I_REG;
          end
        end
        I_REG: begin
          if (bitcnt == 4'h8) begin
            i2c_st <= I_RACK;
            ptr    <= shreg;
          end
        end
        I_RACK, I_WACK: begin
          i2c_st <= I_WR;
          bitcnt <= '0;
        end
        I_WR: begin
          if (bitcnt == 4'h8) begin
            i2c_st <= I_WACK;
            ptr    <= ptr + 1'b1;
          end
        end
        I_RD: begin
          if (bitcnt == 4'h8) begin
            i2c_st <= I_MACK;
            tx     <= 8'hFF;
          end else begin
            tx <= {tx[6:0], 1'b1};
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read selection; reachable in every mode
  assign fifo_en  = cfg_reg[FIFO_EN_BIT];
  assign fifo_pop = rd_load && fifo_en && ptr == REG_PRS_B0;

  always_comb begin
    rd_data = 8'h00;
    if (ptr >= REG_COEF_LO && ptr <= REG_COEF_HI) begin
      rd_data = coef_i[8*(COEF_BYTES-1-int'(ptr-REG_COEF_LO)) +: 8];
    end else begin
      unique case (ptr)
        REG_PRS_B2:    rd_data = fifo_en ? fifo_head.value[23:16]
                                         : prs_res[23:16];
        REG_PRS_B1:    rd_data = fifo_en ? fifo_head.value[15:8]
                                         : prs_res[15:8];
        REG_PRS_B0:    rd_data = fifo_en ? fifo_head.value[7:0]
                                         : prs_res[7:0];
        REG_TMP_B2:    rd_data = tmp_res[23:16];
        REG_TMP_B1:    rd_data = tmp_res[15:8];
        REG_TMP_B0:    rd_data = tmp_res[7:0];
        REG_PRESS_CFG: rd_data = press_cfg;
        REG_TEMP_CFG:  rd_data = temp_cfg;
        REG_MEAS_CFG:  rd_data = {coef_rdy, sensor_rdy, tmp_rdy, prs_rdy,
                                  1'b0, meas_mode};
        REG_CFG:       rd_data = cfg_reg;
        REG_FIFO_STS:  rd_data = {6'h00, fifo_full, fifo_empty};
        REG_PROD_ID:   rd_data = PROD_ID;
        default:       rd_data = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Writable registers and status flags
  assign fifo_flush = wr_fire && ptr == REG_RESET && shreg[FLUSH_BIT];

  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      press_cfg    <= CFG_RESET_VAL;
      temp_cfg     <= CFG_RESET_VAL;
      cfg_reg      <= CFG_RESET_VAL;
      meas_mode    <= MODE_IDLE;
      mode_wr_pend <= 1'b0;
      prs_rdy      <= 1'b0;
      tmp_rdy      <= 1'b0;
    end else begin
      if (wr_fire && ptr == REG_PRESS_CFG) begin
        press_cfg <= shreg & PRESS_CFG_MASK;
      end
      if (wr_fire && ptr == REG_TEMP_CFG) begin
        temp_cfg <= shreg;
      end
      if (wr_fire && ptr == REG_CFG) begin
        cfg_reg <= shreg & CFG_MASK;
      end
      if (wr_fire && ptr == REG_MEAS_CFG) begin
        meas_mode    <= shreg[2:0];
        mode_wr_pend <= (seq_st != SQ_IDLE);
      end else if (store_fire && run_cmd) begin
        if (!mode_wr_pend) begin
          meas_mode <= MODE_IDLE;
        end
        mode_wr_pend <= 1'b0;
      end
      // Set wins over the clear-on-read
      if (store_fire && !result.is_temp) begin
        prs_rdy <= 1'b1;
      end else if (rd_load && ptr == REG_MEAS_CFG) begin
        prs_rdy <= 1'b0;
      end
      if (store_fire && result.is_temp) begin
        tmp_rdy <= 1'b1;
      end else if (rd_load && ptr == REG_MEAS_CFG) begin
        tmp_rdy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate timers, one per quantity
  assign cmd_mode = (meas_mode == MODE_CMD_PRS)
                    || (meas_mode == MODE_CMD_TMP);
  assign bg_en[0] = (meas_mode == MODE_BG_PRS) || (meas_mode == MODE_BG_ALL);
  assign bg_en[1] = (meas_mode == MODE_BG_TMP) || (meas_mode == MODE_BG_ALL);

  for (genvar c = 0; c < 2; c++) begin : g_rate
    logic [9:0] per;
    logic       took;
    assign per  = period_ms(c == 0 ? press_cfg : temp_cfg);
    assign took = start_go && seq_st == SQ_IDLE
                  && !cmd_mode && next_req.is_temp == 1'(c);
    always_ff @(posedge clk_sys_i) begin
      if (rst || !bg_en[c]) begin
        per_cnt[c] <= '0;
        due[c]     <= 1'b1;
      end else if (ms_tick && per_cnt[c] >= per - 1'b1) begin
        per_cnt[c] <= '0;
        due[c]     <= 1'b1;
      end else begin
        if (ms_tick) begin
          per_cnt[c] <= per_cnt[c] + 1'b1;
        end
        if (took) begin
          due[c] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencer with oversampling
  // Pressure wins a tie so a due temperature runs right behind it
  assign next_req.is_temp = cmd_mode ? (meas_mode == MODE_CMD_TMP)
                            : !(bg_en[0] && due[0]);
  assign next_req.prc     = prc_of(next_req.is_temp ? temp_cfg
                                                    : press_cfg);
  assign start_go   = sensor_rdy && (cmd_mode
                      || (bg_en[0] && due[0])
                      || (bg_en[1] && due[1]));
  assign last_samp  = (nsamp == 8'((9'h001 << conv_req_o.prc) - 9'h001));
  assign result.is_temp = conv_req_o.is_temp;
  assign result.value   = 24'(acc >>> conv_req_o.prc);
  assign fifo_push  = seq_st == SQ_STORE && fifo_en && !run_cmd;
  assign store_fire = seq_st == SQ_STORE && (!fifo_push || fifo_rdy);

  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      seq_st       <= SQ_IDLE;
      conv_start_o <= 1'b0;
      conv_req_o   <= '0;
      acc          <= '0;
      nsamp        <= '0;
      run_cmd      <= 1'b0;
      prs_res      <= '0;
      tmp_res      <= '0;
    end else begin
      conv_start_o <= 1'b0;
      unique case (seq_st)
        SQ_IDLE: begin
          if (start_go) begin
            seq_st       <= SQ_CONV;
            conv_req_o   <= next_req;
            run_cmd      <= cmd_mode;
            acc          <= '0;
            nsamp        <= '0;
            conv_start_o <= 1'b1;
          end
        end
        SQ_CONV: begin
          if (sample_valid_i) begin
            acc <= acc + {{8{sample_i[23]}}, sample_i};
            if (last_samp) begin
              seq_st <= SQ_STORE;
            end else begin
              nsamp        <= nsamp + 1'b1;
              conv_start_o <= 1'b1;
            end
          end
        end
        SQ_STORE: begin
          if (store_fire) begin
            seq_st <= SQ_IDLE;
            if (!fifo_push && result.is_temp) begin
              tmp_res <= result.value;
            end else if (!fifo_push) begin
              prs_res <= result.value;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result buffer; full stalls the sequencer
  bmc_fifo #(
    .WIDTH ($bits(bmc_result_t)),
    .DEPTH (RESULT_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (rst),
    .flush_i     (fifo_flush),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_rdy),
    .in_data_i   (result),
    .out_valid_o (),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_head),
    .full_o      (fifo_full),
    .empty_o     (fifo_empty)
  );
endmodule
`default_nettype wire

// ==== bmc_props.sv ====
// Port checker of the barometer control block
`default_nettype none
module bmc_props
  import bmc_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic     clk_sys_i,      // Clock
  input wire logic     srst_i,         // Reset
  input wire logic     scl_i,          // Bus clock
  input wire logic     sda_o,          // Data out
  input wire logic     sda_oe_o,       // Data pull
  input wire logic     conv_start_o,   // Sample request
  input wire bmc_req_t conv_req_o,     // Sample kind
  input wire logic     sample_valid_i  // Sample done
);
  localparam int RDY_CYC = SENSOR_RDY_MS * MS_CYC;
  logic [31:0] up_cnt;
  logic        wait_ans;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  // Cycles since reset, saturating at sensor ready
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      up_cnt <= '0;
    end else if (up_cnt < 32'(RDY_CYC)) begin
      up_cnt <= up_cnt + 32'h1;
    end
  end

  // Set by a sample request, cleared by its answer
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || sample_valid_i) begin
      wait_ans <= 1'b0;
    end else if (conv_start_o) begin
      wait_ans <= 1'b1;
    end
  end

  sequence s_req;
    conv_start_o;
  endsequence
  sequence s_oe_up;
    $rose(sda_oe_o);
  endsequence

  ////////////////////////////////////////////////////////////////////////
  chk_rst_quiet: assert property (
    $fell(srst_i) |-> !conv_start_o && !sda_oe_o)
    else $error("activity right after reset");
  chk_no_early: assert property (
    s_req |-> up_cnt >= 32'(RDY_CYC - 2))
    else $error("sample requested before sensor ready");
  chk_one_sample: assert property (
    s_req |-> !wait_ans)
    else $error("new sample requested before answer");
  chk_req_stable: assert property (
    !conv_start_o |-> $stable(conv_req_o))
    else $error("sample kind changed between requests");
  chk_ack_low: assert property (
    s_oe_up |-> $past(scl_i, 2) == 1'b0)
    else $error("data pulled outside clock low");
  chk_rel_low: assert property (
    $fell(sda_oe_o) |-> $past(scl_i, 2) == 1'b0)
    else $error("data released outside clock low");
  chk_hi_stable: assert property (
    scl_i && $past(scl_i) && $past(scl_i, 2) |-> $stable(sda_oe_o))
    else $error("data changed while clock high");
  chk_ack_hold: assert property (
    s_oe_up |-> sda_oe_o [*4])
    else $error("data pull too short");
  chk_open_drain: assert property (
    sda_oe_o |-> !sda_o)
    else $error("data driven high");
endmodule

bind bmc_top bmc_props #(.MS_CYC(MS_CYC)) u_bmc_props (.clk_sys_i, .srst_i,
  .scl_i, .sda_o, .sda_oe_o, .conv_start_o, .conv_req_o, .sample_valid_i);
`default_nettype wire

// ==== bmc_i2c_host.sv ====
// Bus host model reading and writing the target port
`default_nettype none
module bmc_i2c_host
  import bmc_pkg::*;
(
  output logic      scl_o,   // Bus clock
  output logic      pull_o,  // Pull data low
  input  wire logic sda_i    // Data line level
);
  timeunit 1ns;
  timeprecision 1ns;
  int nak = 0;

  // Clock stands high between frames
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end

  // Also serves as repeated start
  task automatic start();
    #40 pull_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 pull_o = 1'b1;
    #40 scl_o = 1'b0;
  endtask

  task automatic stop();
    #40 pull_o = 1'b1;
    #40 scl_o = 1'b1;
    #40 pull_o = 1'b0;
    #40;
  endtask

  // Nine bits MSB first, the last one the acknowledge slot
  task automatic xbyte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #40 pull_o = !tx[i];
      #40 scl_o = 1'b1;
      #40 rx[i] = sda_i;
      #40 scl_o = 1'b0;
    end
  endtask

  task automatic tx8(input logic [7:0] b);
    logic [8:0] r;
    xbyte({b, 1'b1}, r);
    nak += int'(r[0]);
  endtask

  task automatic wr(input logic [7:0] ra, input int n, input logic [31:0] d);
    start();
    tx8({I2C_ADDR, 1'b0});
    tx8(ra);
    for (int i = n - 1; i >= 0; i--) tx8(d[8*i +: 8]);
    stop();
  endtask

  task automatic rd(input logic [7:0] ra, input int n, output logic [31:0] d);
    logic [8:0] r;
    d = '0;
    start();
    tx8({I2C_ADDR, 1'b0});
    tx8(ra);
    start();
    tx8({I2C_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      xbyte({8'hFF, i == n - 1}, r);
      d = {d[23:0], r[8:1]};
    end
    stop();
  endtask

  // Compensation arithmetic the host applies to raw results
  function automatic int scale_of(input logic [2:0] prc);
    int k [8] = '{524288, 1572864, 3670016, 7864320,
                  253952, 516096, 1040384, 2088960};
    return k[prc];
  endfunction

  function automatic int coef_sx(input logic [19:0] v, input int w);
    return int'($signed(v << (20 - w))) >>> (20 - w);
  endfunction

  function automatic real temp_c(input int c0, input int c1,
                                 input logic [23:0] raw,
                                 input logic [2:0] prc);
    return c0 * 0.5 + c1 * (real'($signed(raw)) / scale_of(prc));
  endfunction
endmodule
`default_nettype wire

// ==== barometer_measurement_control_bench.sv ====
// Self-checking bench of the barometer control block
`default_nettype none
module barometer_measurement_control_bench;
  import bmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          MS    = 50;
  localparam logic [23:0] P_SMP = 24'h12_3456;
  localparam logic [23:0] T_SMP = 24'hF0_1234;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, sample_valid_i = 1'b0;
  logic scl, pull, sda_line, sda_o, sda_oe_o, conv_start_o;
  bmc_req_t                conv_req_o;
  logic [23:0]             sample_i;
  logic [8*COEF_BYTES-1:0] coef_i;
  logic [2:0]              fe_cnt = 3'h0;
  logic [7:0]              kinds = 8'h00;
  int                      starts = 0, error_cnt = 0, total_checks = 0;

  assign sda_line = !(pull | (sda_oe_o & !sda_o));
  assign sample_i = conv_req_o.is_temp ? T_SMP : P_SMP;

  bmc_top #(.MS_CYC(MS)) u_bmc_top (.clk_sys_i, .srst_i, .scl_i(scl),
    .sda_i(sda_line), .sda_o, .sda_oe_o, .conv_start_o, .conv_req_o,
    .sample_valid_i, .sample_i, .coef_i);
  bmc_i2c_host u_bmc_i2c_host (.scl_o(scl), .pull_o(pull), .sda_i(sda_line));

  initial begin
    forever #10 clk_sys_i = !clk_sys_i;
  end

  // Front end answers each sample request three cycles later
  always @(negedge clk_sys_i) begin
    sample_valid_i <= !conv_start_o && fe_cnt == 3'h1;
    if (conv_start_o) begin
      fe_cnt <= 3'h3;
      starts <= starts + 1;
      kinds <= {kinds[6:0], conv_req_o.is_temp};
    end else if (fe_cnt != 3'h0) begin
      fe_cnt <= fe_cnt - 3'h1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_standby();
    logic [31:0] v;
    u_bmc_i2c_host.rd(REG_MEAS_CFG, 1, v);
    chk(v[7:0], 8'h00);
    chk(starts, 0);
  endtask

  task automatic t_ready();
    logic [31:0] v;
    repeat (COEF_RDY_MS * MS) @(negedge clk_sys_i);
    u_bmc_i2c_host.rd(REG_MEAS_CFG, 1, v);
    chk(v[7:6], 2'h3);
    u_bmc_i2c_host.rd(REG_COEF_LO, 3, v);
    chk(v[23:0], coef_i[143 -: 24]);
  endtask

  task automatic t_config();
    logic [31:0] v;
    // Slowest rates, four and two samples
    u_bmc_i2c_host.wr(REG_PRESS_CFG, 2, 32'h0000_0201);
    u_bmc_i2c_host.rd(REG_PRESS_CFG, 2, v);
    chk(v[15:0], 16'h0201);
  endtask

  task automatic t_cmd(input logic [2:0] mode, input logic [7:0] ra,
                       input int n, input logic [23:0] exp);
    logic [31:0] v;
    int          s0;
    s0 = starts;
    v = 32'h7;
    u_bmc_i2c_host.wr(REG_MEAS_CFG, 1, {29'h0, mode});
    for (int k = 0; k < 8 && v[2:0] != 3'h0; k++)
      u_bmc_i2c_host.rd(REG_MEAS_CFG, 1, v);
    chk(v[2:0], 3'h0);
    if (v[2:0] != 3'h0) final_report();
    chk(starts - s0, n);
    u_bmc_i2c_host.rd(ra, 3, v);
    chk(v[23:0], exp);
  endtask

  task automatic t_bg(input logic [2:0] mode, input int n,
                      input logic [5:0] kexp);
    logic [31:0] v;
    int          s0;
    s0 = starts;
    u_bmc_i2c_host.wr(REG_MEAS_CFG, 1, {29'h0, mode});
    u_bmc_i2c_host.wr(REG_MEAS_CFG, 1, 32'h0);
    chk(starts - s0, n);
    chk(kinds[5:0], kexp);
    u_bmc_i2c_host.rd(REG_TMP_B2, 3, v);
    chk(v[23:0], T_SMP);
  endtask

  task automatic t_fifo();
    logic [31:0] v;
    u_bmc_i2c_host.wr(REG_CFG, 1, 32'h0000_0002);
    u_bmc_i2c_host.wr(REG_MEAS_CFG, 1, {29'h0, MODE_BG_ALL});
    u_bmc_i2c_host.wr(REG_MEAS_CFG, 1, 32'h0);
    u_bmc_i2c_host.rd(REG_FIFO_STS, 1, v);
    chk(v[1:0], 2'h0);
    u_bmc_i2c_host.rd(REG_PRS_B2, 3, v);
    chk(v[23:0], P_SMP);
    u_bmc_i2c_host.rd(REG_PRS_B2, 3, v);
    chk(v[23:0], T_SMP);
    u_bmc_i2c_host.rd(REG_FIFO_STS, 1, v);
    chk(v[1:0], 2'h1);
    u_bmc_i2c_host.wr(REG_CFG, 1, 32'h0);
  endtask

  task automatic t_badaddr();
    logic [8:0] r;
    u_bmc_i2c_host.start();
    u_bmc_i2c_host.xbyte({7'h22, 2'h1}, r);
    u_bmc_i2c_host.stop();
    chk(r[0], 1'b1);
    chk(u_bmc_i2c_host.nak, 0);
  endtask

  initial begin
    for (int i = 0; i < COEF_BYTES; i++) coef_i[8*i +: 8] = 8'h31 + 8'(i);
    repeat (4) @(negedge clk_sys_i);
    srst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    t_standby();
    t_ready();
    t_config();
    t_cmd(MODE_CMD_PRS, REG_PRS_B2, 4, P_SMP);
    t_cmd(MODE_CMD_TMP, REG_TMP_B2, 2, T_SMP);
    t_bg(MODE_BG_PRS, 4, 6'h30);
    t_bg(MODE_BG_TMP, 2, 6'h03);
    t_bg(MODE_BG_ALL, 6, 6'h03);
    t_fifo();
    t_badaddr();
    final_report();
  end
endmodule
`default_nettype wire
